/* pkg/pfs_defines.svh */
// Register offsets, bit positions and reset values of the flag and status bank
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

`define PFS_ADDR_W 8
`define PFS_OFF_FLAGS 8'h2C
`define PFS_OFF_STATE 8'h30
`define PFS_FLAGS_RST 32'h0000_0000
`define PFS_STATE_RST 32'h0000_0001
`define PFS_ZERO32 32'h0000_0000

// Event flag bit positions
`define PFS_F_CH 16
`define PFS_F_HARD 14
`define PFS_F_SOFT_B 13
`define PFS_F_SOFT_A 12
`define PFS_F_DBG 11
`define PFS_F_ERR 3
`define PFS_F_CNT 2
`define PFS_F_TRG 1
`define PFS_F_WRAP 0

// Timer state bit positions
`define PFS_S_LVL 24
`define PFS_S_BV 16
`define PFS_S_HARD 14
`define PFS_S_SOFT_B 13
`define PFS_S_SOFT_A 12
`define PFS_S_IN_HARD1 11
`define PFS_S_IN_HARD0 10
`define PFS_S_IN_SOFT_B 9
`define PFS_S_IN_SOFT_A 8
`define PFS_S_PERIOD_BUFFER_VALID 7
`define PFS_S_WAVEFORM_BUFFER_VALID 6
`define PFS_S_PATTERN_BUFFER_VALID 5
`define PFS_S_DBG 3
`define PFS_S_IDX 1
`define PFS_S_STOP 0

// Synchronised trip pin order
`define PFS_PIN_SOFT_A 0
`define PFS_PIN_SOFT_B 1
`define PFS_PIN_HARD0 2
`define PFS_PIN_HARD1 3

`endif

/* pkg/pfs_pkg.sv */
// Types carried between the timer core and the flag and status bank
`default_nettype none
package pfs_pkg;

    // One-cycle event pulses from the timer core, all on clk_sys
    typedef struct packed {
        logic [3:0] chan_match;
        logic [3:0] chan_capture;
        logic [3:0] chan_cc_read;
        logic [3:0] chan_buf_write;
        logic [1:0] hard_trip;
        logic soft_trip_b;
        logic soft_trip_a;
        logic soft_b_resume;
        logic soft_a_resume;
        logic debug_enter;
        logic counter_evt;
        logic retrigger;
        logic wrap;
        logic update;
        logic stop_cmd;
        logic count_step;
        logic per_buf_write;
        logic wave_buf_write;
        logic patt_buf_write;
    } pfs_evt_t;

    // Configuration and live levels from the timer core
    typedef struct packed {
        logic [3:0] capture_mode;
        logic [3:0] chan_output_level;
        logic lock_update;
        logic oneshot;
        logic two_phase_ramp;
        logic cycle_b;
        logic debug_mode;
        logic soft_a_sw_halt;
        logic soft_b_sw_halt;
        logic [31:0] irq_enable;
    } pfs_cfg_t;

endpackage : pfs_pkg
`default_nettype wire

/* logic/pfs_regs.sv */
// Event flag and timer state registers of the PWM control timer
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"

module pfs_regs (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [`PFS_ADDR_W-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic count_tick,
    input wire pfs_pkg::pfs_evt_t evt,
    input wire pfs_pkg::pfs_cfg_t cfg,
    input wire logic [3:0] trip_pin,
    output logic irq,
    output logic [1:0] hard_trip_state,
    output logic hard_trip_resume,
    output logic [1:0] soft_trip_release
);

    logic [31:0] flags_reg;
    logic [31:0] flags_next;
    logic [31:0] pend_reg;
    logic [31:0] pend_next;
    logic [31:0] delayed_set;
    logic [31:0] direct_set;
    logic [31:0] flag_clr;
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [3:0] lvl_reg;
    logic [3:0] bv_reg;
    logic [1:0] hard_reg;
    logic soft_a_reg;
    logic soft_b_reg;
    logic per_bv_reg;
    logic wave_bv_reg;
    logic patt_bv_reg;
    logic dbg_reg;
    logic idx_reg;
    logic stop_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    logic resume_reg;
    logic [1:0] release_reg;
    logic wr_flags;
    logic wr_state;
    logic [31:0] state_rd;
    logic [1:0] hard_clr;
    logic soft_a_clr;
    logic soft_b_clr;

    assign wr_flags = bus_wr && (bus_addr == `PFS_OFF_FLAGS);
    assign wr_state = bus_wr && (bus_addr == `PFS_OFF_STATE);

    // Trip pins arrive from outside; two stages before anything reads them
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end
        else
        begin
            pin_meta_reg <= trip_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Events that set their flag on the counter tick after they happen
    always_comb
    begin
        delayed_set = `PFS_ZERO32;
        delayed_set[`PFS_F_CH +: 4] = evt.chan_match | evt.chan_capture;
        delayed_set[`PFS_F_HARD +: 2] = evt.hard_trip;
        delayed_set[`PFS_F_SOFT_B] = evt.soft_trip_b;
        delayed_set[`PFS_F_SOFT_A] = evt.soft_trip_a;
        delayed_set[`PFS_F_DBG] = evt.debug_enter;
        delayed_set[`PFS_F_CNT] = evt.counter_evt;
        delayed_set[`PFS_F_TRG] = evt.retrigger;
        delayed_set[`PFS_F_WRAP] = evt.wrap;
    end

    // A capture finding its flag still up has nowhere to go
    always_comb
    begin
        direct_set = `PFS_ZERO32;
        direct_set[`PFS_F_ERR] = |(evt.chan_capture & flags_reg[`PFS_F_CH +: 4]);
    end

    always_comb
    begin
        flag_clr = wr_flags ? bus_wdata : `PFS_ZERO32;
        flag_clr[`PFS_F_CH +: 4] = flag_clr[`PFS_F_CH +: 4]
            | (evt.chan_cc_read & cfg.capture_mode);
    end

    // Pending events wait for the tick; an event on the tick waits for the next one
    assign pend_next = (pend_reg & ~{32{count_tick}}) | delayed_set;
    assign flags_next = (flags_reg & ~flag_clr)
        | (pend_reg & {32{count_tick}}) | direct_set;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend_reg <= `PFS_ZERO32;
            flags_reg <= `PFS_FLAGS_RST;
        end
        else
        begin
            pend_reg <= pend_next;
            flags_reg <= flags_next;
        end
    end

    // Registered from the next flag value so the request tracks the flags exactly
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(flags_next & cfg.irq_enable);
    end

    // Channel buffer valid bits
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            bv_reg <= 4'h0;
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (cfg.capture_mode[i])
                begin
                    if (evt.chan_capture[i])
                        bv_reg[i] <= 1'b1;
                    else if (evt.chan_cc_read[i])
                        bv_reg[i] <= 1'b0;
                end
                else
                begin
                    if (evt.chan_buf_write[i])
                        bv_reg[i] <= 1'b1;
                    else if (evt.update
                        || (wr_state && bus_wdata[`PFS_S_BV + i] && cfg.lock_update))
                        bv_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Period, waveform and pattern buffer valid bits
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            per_bv_reg <= 1'b0;
            wave_bv_reg <= 1'b0;
            patt_bv_reg <= 1'b0;
        end
        else
        begin
            per_bv_reg <= evt.per_buf_write | (per_bv_reg
                & ~(evt.update & cfg.lock_update)
                & ~(wr_state & bus_wdata[`PFS_S_PERIOD_BUFFER_VALID]));
            wave_bv_reg <= evt.wave_buf_write | (wave_bv_reg
                & ~(evt.update & cfg.lock_update)
                & ~(wr_state & bus_wdata[`PFS_S_WAVEFORM_BUFFER_VALID]));
            patt_bv_reg <= evt.patt_buf_write | (patt_bv_reg
                & ~(evt.update & cfg.lock_update)
                & ~(wr_state & bus_wdata[`PFS_S_PATTERN_BUFFER_VALID]));
        end
    end

    // Trip states: set at once, software clear only once the input has gone
    assign hard_clr[0] = wr_state && bus_wdata[`PFS_S_HARD]
        && !pin_sync_reg[`PFS_PIN_HARD0];
    assign hard_clr[1] = wr_state && bus_wdata[`PFS_S_HARD + 1]
        && !pin_sync_reg[`PFS_PIN_HARD1];
    assign soft_a_clr = evt.soft_a_resume || (wr_state && bus_wdata[`PFS_S_SOFT_A]
        && !pin_sync_reg[`PFS_PIN_SOFT_A]);
    assign soft_b_clr = evt.soft_b_resume || (wr_state && bus_wdata[`PFS_S_SOFT_B]
        && !pin_sync_reg[`PFS_PIN_SOFT_B]);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hard_reg <= 2'b00;
            soft_a_reg <= 1'b0;
            soft_b_reg <= 1'b0;
        end
        else
        begin
            hard_reg <= evt.hard_trip | (hard_reg & ~hard_clr);
            soft_a_reg <= evt.soft_trip_a | (soft_a_reg & ~soft_a_clr);
            soft_b_reg <= evt.soft_trip_b | (soft_b_reg & ~soft_b_clr);
        end
    end

    // Pulses back to the counter; it keeps its count, restart is software's job
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            resume_reg <= 1'b0;
            release_reg <= 2'b00;
        end
        else
        begin
            resume_reg <= |(hard_reg & hard_clr & ~evt.hard_trip);
            release_reg[0] <= soft_a_reg && soft_a_clr && !evt.soft_trip_a
                && cfg.soft_a_sw_halt;
            release_reg[1] <= soft_b_reg && soft_b_clr && !evt.soft_trip_b
                && cfg.soft_b_sw_halt;
        end
    end

    // Debug halt state, stopped bit, ramp index and mirrored output levels
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dbg_reg <= 1'b0;
            stop_reg <= 1'b1;
            idx_reg <= 1'b0;
            lvl_reg <= 4'h0;
        end
        else
        begin
            dbg_reg <= evt.debug_enter | (dbg_reg
                & ~(wr_state & bus_wdata[`PFS_S_DBG] & ~cfg.debug_mode));
            stop_reg <= evt.stop_cmd | (evt.update & cfg.oneshot)
                | (stop_reg & ~evt.count_step);
            idx_reg <= cfg.two_phase_ramp & cfg.cycle_b;
            lvl_reg <= cfg.chan_output_level;
        end
    end

    always_comb
    begin
        state_rd = `PFS_ZERO32;
        state_rd[`PFS_S_LVL +: 4] = lvl_reg;
        state_rd[`PFS_S_BV +: 4] = bv_reg;
        state_rd[`PFS_S_HARD +: 2] = hard_reg;
        state_rd[`PFS_S_SOFT_B] = soft_b_reg;
        state_rd[`PFS_S_SOFT_A] = soft_a_reg;
        state_rd[`PFS_S_IN_HARD1] = pin_sync_reg[`PFS_PIN_HARD1];
        state_rd[`PFS_S_IN_HARD0] = pin_sync_reg[`PFS_PIN_HARD0];
        state_rd[`PFS_S_IN_SOFT_B] = pin_sync_reg[`PFS_PIN_SOFT_B];
        state_rd[`PFS_S_IN_SOFT_A] = pin_sync_reg[`PFS_PIN_SOFT_A];
        state_rd[`PFS_S_PERIOD_BUFFER_VALID] = per_bv_reg;
        state_rd[`PFS_S_WAVEFORM_BUFFER_VALID] = wave_bv_reg;
        state_rd[`PFS_S_PATTERN_BUFFER_VALID] = patt_bv_reg;
        state_rd[`PFS_S_DBG] = dbg_reg;
        state_rd[`PFS_S_IDX] = idx_reg;
        state_rd[`PFS_S_STOP] = stop_reg;
    end

    // Read data stand for exactly one cycle; unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rdata_reg <= `PFS_ZERO32;
        else if (bus_rd && bus_addr == `PFS_OFF_FLAGS)
            rdata_reg <= flags_reg;
        else if (bus_rd && bus_addr == `PFS_OFF_STATE)
            rdata_reg <= state_rd;
        else
            rdata_reg <= `PFS_ZERO32;
    end

    assign bus_rdata = rdata_reg;
    assign irq = irq_reg;
    assign hard_trip_state = hard_reg;
    assign hard_trip_resume = resume_reg;
    assign soft_trip_release = release_reg;

endmodule : pfs_regs
`default_nettype wire

/* verif/pfs_regs_monitor.sv */
// Assertion checker for the flag and status register bank
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"
module pfs_regs_monitor (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [`PFS_ADDR_W-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic count_tick,
    input wire pfs_pkg::pfs_evt_t evt,
    input wire pfs_pkg::pfs_cfg_t cfg,
    input wire logic [3:0] trip_pin,
    input wire logic irq,
    input wire logic [1:0] hard_trip_state,
    input wire logic hard_trip_resume,
    input wire logic [1:0] soft_trip_release
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    logic st_wr;
    assign st_wr = bus_wr && bus_addr == `PFS_OFF_STATE;
    sequence seq_wrap_tick;
        evt.wrap ##1 (count_tick && cfg.irq_enable[0]);
    endsequence
    // Three samples so the two-stage synchroniser has settled
    sequence seq_hard0_low;
        (!trip_pin[2])[*3];
    endsequence
    AST_WRAP_IRQ: assert property (seq_wrap_tick |=> irq)
        else $error("wrap flag did not raise irq");
    AST_IRQ_OFF: assert property (cfg.irq_enable == 32'h0000_0000 |=> !irq)
        else $error("irq high with all enables off");
    AST_HARD0_SET: assert property (evt.hard_trip[0] |=> hard_trip_state[0])
        else $error("hard trip 0 state not set");
    AST_HARD1_SET: assert property (
        $rose(hard_trip_state[1]) |-> $past(evt.hard_trip[1]))
        else $error("hard trip 1 state rose without trip");
    AST_HARD0_HOLD: assert property (
        (trip_pin[2])[*3] ##0 hard_trip_state[0] |=> hard_trip_state[0])
        else $error("hard trip 0 state cleared with input high");
    AST_HARD0_CLR: assert property (
        seq_hard0_low ##0 (st_wr && bus_wdata[14] && hard_trip_state[0] && !evt.hard_trip[0])
        |=> !hard_trip_state[0] && hard_trip_resume)
        else $error("hard trip 0 clear or resume missing");
    AST_RESUME_CAUSE: assert property (
        hard_trip_resume |-> $fell(hard_trip_state[0]) || $fell(hard_trip_state[1]))
        else $error("resume pulse without state clear");
    AST_REL_A: assert property (
        soft_trip_release[0] |-> $past(cfg.soft_a_sw_halt))
        else $error("trip A release without software halt");
    AST_REL_B: assert property (
        soft_trip_release[1] |-> $past(cfg.soft_b_sw_halt))
        else $error("trip B release without software halt");
endmodule : pfs_regs_monitor
bind pfs_regs pfs_regs_monitor u_mon (.clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .count_tick(count_tick), .evt(evt), .cfg(cfg), .trip_pin(trip_pin), .irq(irq),
    .hard_trip_state(hard_trip_state), .hard_trip_resume(hard_trip_resume),
    .soft_trip_release(soft_trip_release));
`default_nettype wire

/* verif/tb_pfs_regs.sv */
// Self-checking bench of the flag and status register bank
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"
module tb_pfs_regs;
    localparam logic [7:0] fl_off = `PFS_OFF_FLAGS;
    localparam logic [7:0] st_off = `PFS_OFF_STATE;
    logic clk_sys = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] bus_addr = '0;
    logic [31:0] bus_wdata = '0;
    logic bus_wr = 1'h0;
    logic bus_rd = 1'h0;
    logic [31:0] bus_rdata;
    logic count_tick = 1'h0;
    pfs_pkg::pfs_evt_t evt = '0;
    pfs_pkg::pfs_evt_t e;
    pfs_pkg::pfs_cfg_t cfg = '0;
    logic [3:0] trip_pin = 4'h0;
    logic irq;
    logic [1:0] hard_trip_state;
    logic hard_trip_resume;
    logic [1:0] soft_trip_release;
    int bad_count = 0;
    int check_count = 0;
    always #5 clk_sys = ~clk_sys;
    pfs_regs u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .count_tick(count_tick), .evt(evt), .cfg(cfg), .trip_pin(trip_pin), .irq(irq),
        .hard_trip_state(hard_trip_state), .hard_trip_resume(hard_trip_resume),
        .soft_trip_release(soft_trip_release));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_sys);
        bus_rd <= 1'h1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'h0;
        #1;
        chk(name, exp, bus_rdata);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_wr <= 1'h1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'h0;
    endtask : wr
    task automatic ev(input pfs_pkg::pfs_evt_t v);
        @(posedge clk_sys);
        evt <= v;
        @(posedge clk_sys);
        evt <= '0;
    endtask : ev
    task automatic tick();
        @(posedge clk_sys);
        count_tick <= 1'h1;
        @(posedge clk_sys);
        count_tick <= 1'h0;
    endtask : tick
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    initial
    begin
        #100000;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'h1;
        rd(fl_off, `PFS_FLAGS_RST, "flags reset");
        rd(st_off, `PFS_STATE_RST, "state reset");
        rd(8'h34, 32'h0000_0000, "unmapped");
        $display("test reset done");
        cfg.irq_enable <= 32'hFFFF_FFFF;
        e = '0;
        e.chan_match = 4'hF;
        e.hard_trip = 2'h3;
        e.soft_trip_b = 1'h1;
        e.soft_trip_a = 1'h1;
        e.debug_enter = 1'h1;
        e.counter_evt = 1'h1;
        e.retrigger = 1'h1;
        e.wrap = 1'h1;
        ev(e);
        rd(fl_off, 32'h0000_0000, "flags before tick");
        rd(st_off, 32'h0000_F009, "trip states");
        tick();
        rd(fl_off, 32'h000F_F807, "flags after tick");
        chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
        wr(fl_off, 32'h0000_0005);
        rd(fl_off, 32'h000F_F802, "partial clear");
        wr(fl_off, 32'hFFFF_FFFF);
        rd(fl_off, 32'h0000_0000, "full clear");
        chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
        e = '0;
        e.wrap = 1'h1;
        @(posedge clk_sys);
        evt <= e;
        @(posedge clk_sys);
        evt <= '0;
        count_tick <= 1'h1;
        bus_wr <= 1'h1;
        bus_addr <= fl_off;
        bus_wdata <= 32'h0000_0001;
        @(posedge clk_sys);
        count_tick <= 1'h0;
        bus_wr <= 1'h0;
        rd(fl_off, 32'h0000_0001, "set wins");
        wr(fl_off, 32'h0000_0001);
        $display("test flags done");
        @(posedge clk_sys);
        trip_pin <= 4'hF;
        cfg.soft_a_sw_halt <= 1'h1;
        cfg.soft_b_sw_halt <= 1'h1;
        // Pins pass two stages before the status bits see them
        @(posedge clk_sys);
        rd(st_off, 32'h0000_FF09, "inputs high");
        wr(st_off, 32'h0000_F000);
        rd(st_off, 32'h0000_FF09, "clear refused");
        @(posedge clk_sys);
        trip_pin <= 4'h0;
        @(posedge clk_sys);
        rd(st_off, 32'h0000_F009, "inputs low");
        wr(st_off, 32'h0000_F008);
        #1;
        chk("hard state", 32'h0000_0000, {30'h0000_0000, hard_trip_state});
        chk("resume", 32'h0000_0001, {31'h0000_0000, hard_trip_resume});
        chk("release", 32'h0000_0003, {30'h0000_0000, soft_trip_release});
        rd(st_off, 32'h0000_0001, "states cleared");
        $display("test trips done");
        @(posedge clk_sys);
        cfg.capture_mode <= 4'h1;
        e = '0;
        e.chan_capture = 4'h1;
        ev(e);
        tick();
        rd(fl_off, 32'h0001_0000, "capture flag");
        rd(st_off, 32'h0001_0001, "capture valid");
        ev(e);
        rd(fl_off, 32'h0001_0008, "overrun");
        e = '0;
        e.chan_cc_read = 4'h1;
        ev(e);
        rd(fl_off, 32'h0000_0008, "read clears flag");
        rd(st_off, 32'h0000_0001, "read clears valid");
        $display("test capture done");
        @(posedge clk_sys);
        cfg.capture_mode <= 4'h0;
        cfg.chan_output_level <= 4'hA;
        cfg.two_phase_ramp <= 1'h1;
        cfg.cycle_b <= 1'h1;
        cfg.lock_update <= 1'h1;
        e = '0;
        e.chan_buf_write = 4'h2;
        e.per_buf_write = 1'h1;
        e.wave_buf_write = 1'h1;
        e.patt_buf_write = 1'h1;
        e.count_step = 1'h1;
        ev(e);
        rd(st_off, 32'h0A02_00E2, "status mirror");
        wr(st_off, 32'h0002_0060);
        rd(st_off, 32'h0A00_0082, "buffer clear");
        e = '0;
        e.update = 1'h1;
        e.stop_cmd = 1'h1;
        ev(e);
        rd(st_off, 32'h0A00_0003, "update and stop");
        $display("test status done");
        @(posedge clk_sys);
        cfg.lock_update <= 1'h0;
        cfg.oneshot <= 1'h1;
        e = '0;
        e.chan_buf_write = 4'h4;
        e.per_buf_write = 1'h1;
        e.soft_trip_a = 1'h1;
        e.count_step = 1'h1;
        ev(e);
        rd(st_off, 32'h0A04_1082, "trip A and buffers");
        // Without lock the compare valid bit ignores a write of one
        wr(st_off, 32'h0004_0080);
        rd(st_off, 32'h0A04_1002, "unlocked write");
        e = '0;
        e.update = 1'h1;
        e.soft_a_resume = 1'h1;
        ev(e);
        #1;
        chk("release", 32'h0000_0001, {30'h0000_0000, soft_trip_release});
        rd(st_off, 32'h0A00_0003, "one-shot update");
        chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
        @(posedge clk_sys);
        cfg.irq_enable <= 32'h0000_0000;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
        $display("test resume done");
        wrap_up();
    end
endmodule : tb_pfs_regs
`default_nettype wire
